// ===== rtl/alu_subset_pkg.sv
// Package of encodings, field positions, reset values and phase codes for the instruction subset
package alu_subset_pkg;

  // Opcode field, instruction bits 11:8 for byte-oriented file operations
  localparam logic [3:0] OP_REG_MINUS_ACC = 4'h2;
  localparam logic [3:0] OP_DECREMENT_REG = 4'h3;
  localparam logic [3:0] OP_REG_XOR_ACC   = 4'h6;
  localparam logic [3:0] OP_COMPLEMENT    = 4'h9;
  localparam logic [3:0] OP_DEC_SKIP_ZERO = 4'hB;
  localparam logic [3:0] OP_NIBBLE_EXCH   = 4'hE;

  // Group codes in instruction bits 13:12 (file 00, literal 11) and literal opcodes
  localparam logic [1:0] GRP_FILE         = 2'h0;
  localparam logic [1:0] GRP_LITERAL      = 2'h3;
  localparam logic [2:0] LOP_MINUS_ACC    = 3'h6;
  localparam logic [3:0] LOP_XOR_ACC      = 4'hA;

  // Whole-word encodings
  localparam logic [13:0] POWER_DOWN_WORD = 14'h0063;
  localparam logic [10:0] DIR_LOAD_HIGH   = 11'h00C;
  localparam logic [2:0]  DIR_LOAD_MIN    = 3'h5;
  localparam logic [2:0]  DIR_LOAD_MAX    = 3'h7;

  // Field positions inside the instruction word
  localparam int DEST_BIT   = 7;
  localparam int INSN_WIDTH = 14;
  localparam int ADDR_WIDTH = 7;

  // Reset values
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] WDT_CLEAR = 8'h00;

  // Phase codes, one-hot
  typedef enum logic [3:0]
  {
    PH_DECODE  = 4'h1,
    PH_READ    = 4'h2,
    PH_PROCESS = 4'h4,
    PH_WRITE   = 4'h8
  } phase_t;

endpackage

// ===== rtl/direction_regs.sv
// Small storage for the three port direction registers
`timescale 1ns/1ns
`default_nettype none
module direction_regs
#(
  parameter int WIDTH = 8,
  parameter int COUNT = 3
)
(
  input  wire logic                     core_clk_in,
  input  wire logic                     nrst_in,
  input  wire logic                     wr_en_in,
  input  wire logic [1:0]               wr_idx_in,
  input  wire logic [WIDTH-1:0]         wr_data_in,
  input  wire logic [1:0]               rd_idx_in,
  output logic      [WIDTH-1:0]         rd_data_out
);

  // Direction storage; ports come up as inputs (all ones)
  logic [WIDTH-1:0] dir_mem [COUNT];

  // ------------------------------------------------------------
  // Write port
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      for (int i = 0; i < COUNT; i++)
        dir_mem[i] <= '1;
    end
    else if (wr_en_in && (int'(wr_idx_in) < COUNT))
    begin
      dir_mem[wr_idx_in] <= wr_data_in;
    end
  end

  // ------------------------------------------------------------
  // Registered read port
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rd_data_out <= '1;
    else if (int'(rd_idx_in) < COUNT)
      rd_data_out <= dir_mem[rd_idx_in];
    else
      rd_data_out <= '0;
  end

endmodule
`default_nettype wire

// ===== rtl/alu_instruction_subset.sv
// Four-phase decode and execute core for a subset of the 8-bit instruction set
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Decode, read, compute, write across four phases
// - decrement_reg subtracts one, zero flag only
// - complement_reg inverts file value, zero flag only
// - Accumulator target leaves source register unchanged
// - decrement_skip_zero skips next when result zero
// - Power-down clears watchdog, sets timeout, clears power-down
// - Power-down one cycle, sleeps after the final phase with the phase held at decode
// - reg_minus_acc: carry means no borrow
// - nibble_exchange swaps nibbles, flags unchanged
// - direction_load copies accumulator to direction register
module alu_instruction_subset
#(
  parameter int DATA_WIDTH = 8
)
(
  input  wire logic                  core_clk_in,
  input  wire logic                  nrst_in,
  input  wire logic [13:0]           insn_in,
  input  wire logic                  insn_valid_in,
  input  wire logic [DATA_WIDTH-1:0] file_rdata_in,
  input  wire logic                  wake_in,
  output logic      [3:0]            phase_out,
  output logic      [6:0]            file_addr_out,
  output logic                       file_rd_out,
  output logic                       file_wr_out,
  output logic      [DATA_WIDTH-1:0] file_wdata_out,
  output logic      [DATA_WIDTH-1:0] acc_out,
  output logic                       zero_flag_out,
  output logic                       carry_flag_out,
  output logic                       nibble_borrow_flag_out,
  output logic                       timeout_flag_out,
  output logic                       power_down_flag_out,
  output logic      [7:0]            watchdog_counter_out,
  output logic                       wdt_prescaler_clr_out,
  output logic                       sleep_out,
  output logic                       skip_out,
  output logic                       insn_done_out,
  output logic      [DATA_WIDTH-1:0] dir_rdata_out,
  input  wire logic [1:0]            dir_rd_idx_in
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  alu_subset_pkg::phase_t phase;              // Current phase of the cycle
  alu_subset_pkg::phase_t next_phase;         // Phase for the next edge
  logic [13:0]            insn;               // Instruction latched at decode
  logic                   skip_cycle;         // Current cycle is a forced no-op
  logic                   skip_pending;       // Next cycle must be discarded
  logic [DATA_WIDTH-1:0]  operand;            // Operand captured in the read phase
  logic [DATA_WIDTH-1:0]  result;             // Result held from compute to write
  logic                   res_z;              // Zero flag candidate
  logic                   res_c;              // Carry candidate
  logic                   res_dc;             // Digit carry candidate
  logic                   upd_z;              // Zero flag is written
  logic                   upd_cdc;            // Carry and digit carry written
  logic                   to_file;            // Destination is the file register
  logic                   writes;             // Instruction writes a destination
  logic                   is_sleep;           // Decoded power-down
  logic                   is_dir;             // Decoded direction_load
  logic                   is_lit;             // Operand comes from the literal
  logic [DATA_WIDTH-1:0]  next_result;        // Combinational compute output
  logic [DATA_WIDTH:0]    diff;               // Subtract with carry out
  logic [4:0]             ndiff;              // Low-nibble subtract

  // Add with carry-in; subtraction is a + ~b + 1, so carry out means no borrow
  function automatic logic [DATA_WIDTH:0] add_c(input logic [DATA_WIDTH-1:0] a,
                                                input logic [DATA_WIDTH-1:0] b);
    add_c = {1'b0, a} + {1'b0, b} + {{DATA_WIDTH{1'b0}}, 1'b1};
  endfunction

  // ------------------------------------------------------------
  // Phase sequencer, halted while asleep
  // ------------------------------------------------------------
  always_comb
  begin
    next_phase = phase;
    case (phase)
      alu_subset_pkg::PH_DECODE:  next_phase = alu_subset_pkg::PH_READ;
      alu_subset_pkg::PH_READ:    next_phase = alu_subset_pkg::PH_PROCESS;
      alu_subset_pkg::PH_PROCESS: next_phase = alu_subset_pkg::PH_WRITE;
      alu_subset_pkg::PH_WRITE:   next_phase = alu_subset_pkg::PH_DECODE;
      default:                    next_phase = alu_subset_pkg::PH_DECODE;
    endcase
  end

  // Oscillator stop is modelled by freezing the phase clock in sleep
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      phase <= alu_subset_pkg::PH_DECODE;
    else if (!sleep_out)
      phase <= next_phase;
  end

  // ------------------------------------------------------------
  // Decode of the latched word
  // ------------------------------------------------------------
  always_comb
  begin
    is_sleep = (insn == alu_subset_pkg::POWER_DOWN_WORD);
    is_dir   = (insn[13:3] == alu_subset_pkg::DIR_LOAD_HIGH)
               && (insn[2:0] >= alu_subset_pkg::DIR_LOAD_MIN)
               && (insn[2:0] <= alu_subset_pkg::DIR_LOAD_MAX);
    is_lit   = (insn[13:12] == alu_subset_pkg::GRP_LITERAL);
    to_file  = !is_lit && insn[alu_subset_pkg::DEST_BIT];
    writes   = 1'b0;
    upd_z    = 1'b0;
    upd_cdc  = 1'b0;
    if (skip_cycle || is_sleep || is_dir)
    begin
      writes = 1'b0;
    end
    else if (is_lit)
    begin
      if (insn[11:9] == alu_subset_pkg::LOP_MINUS_ACC)
      begin
        writes  = 1'b1;
        upd_z   = 1'b1;
        upd_cdc = 1'b1;
      end
      else if (insn[11:8] == alu_subset_pkg::LOP_XOR_ACC)
      begin
        writes = 1'b1;
        upd_z  = 1'b1;
      end
    end
    else if (insn[13:12] == alu_subset_pkg::GRP_FILE)
    begin
      case (insn[11:8])
        alu_subset_pkg::OP_REG_MINUS_ACC: begin writes = 1'b1; upd_z = 1'b1; upd_cdc = 1'b1; end
        alu_subset_pkg::OP_DECREMENT_REG: begin writes = 1'b1; upd_z = 1'b1; end
        alu_subset_pkg::OP_REG_XOR_ACC:   begin writes = 1'b1; upd_z = 1'b1; end
        alu_subset_pkg::OP_COMPLEMENT:    begin writes = 1'b1; upd_z = 1'b1; end
        alu_subset_pkg::OP_DEC_SKIP_ZERO: writes = 1'b1;
        alu_subset_pkg::OP_NIBBLE_EXCH:   writes = 1'b1;
        default:                          writes = 1'b0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Compute
  // ------------------------------------------------------------
  always_comb
  begin
    diff        = add_c(operand, ~acc_out);
    ndiff       = {1'b0, operand[3:0]} + {1'b0, ~acc_out[3:0]} + 5'h01;
    next_result = operand;
    if (is_lit && insn[11:8] == alu_subset_pkg::LOP_XOR_ACC)
      next_result = operand ^ acc_out;
    else if (is_lit)
      next_result = diff[DATA_WIDTH-1:0];
    else
    begin
      case (insn[11:8])
        alu_subset_pkg::OP_REG_MINUS_ACC: next_result = diff[DATA_WIDTH-1:0];
        alu_subset_pkg::OP_DECREMENT_REG: next_result = operand - 8'h01;
        alu_subset_pkg::OP_DEC_SKIP_ZERO: next_result = operand - 8'h01;
        alu_subset_pkg::OP_REG_XOR_ACC:   next_result = operand ^ acc_out;
        alu_subset_pkg::OP_COMPLEMENT:    next_result = ~operand;
        alu_subset_pkg::OP_NIBBLE_EXCH:   next_result = {operand[3:0], operand[7:4]};
        default:                          next_result = operand;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Latch instruction at decode, operand at read, result at process
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      insn       <= '0;
      skip_cycle <= 1'b0;
      operand    <= '0;
      result     <= '0;
      res_z      <= 1'b0;
      res_c      <= 1'b0;
      res_dc     <= 1'b0;
    end
    else if (!sleep_out)
    begin
      if (phase == alu_subset_pkg::PH_DECODE)
      begin
        // Invalid fetch becomes a no-op cycle
        insn       <= insn_valid_in ? insn_in : 14'h0000;
        skip_cycle <= skip_pending;
      end
      if (phase == alu_subset_pkg::PH_READ)
        operand <= is_lit ? insn[7:0] : file_rdata_in;
      if (phase == alu_subset_pkg::PH_PROCESS)
      begin
        result <= next_result;
        res_z  <= (next_result == '0);
        res_c  <= diff[DATA_WIDTH];
        res_dc <= ndiff[4];
      end
    end
  end

  // ------------------------------------------------------------
  // Write phase: accumulator, flags and skip request
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      acc_out                <= alu_subset_pkg::ACC_RESET;
      zero_flag_out          <= 1'b0;
      carry_flag_out         <= 1'b0;
      nibble_borrow_flag_out <= 1'b0;
      skip_pending           <= 1'b0;
    end
    else if (phase == alu_subset_pkg::PH_WRITE && !sleep_out)
    begin
      if (writes && !to_file)
        acc_out <= result;
      if (upd_z)
        zero_flag_out <= res_z;
      if (upd_cdc)
      begin
        carry_flag_out         <= res_c;
        nibble_borrow_flag_out <= res_dc;
      end
      skip_pending <= writes && (insn[11:8] == alu_subset_pkg::OP_DEC_SKIP_ZERO)
                      && !is_lit && res_z;
    end
  end

  // ------------------------------------------------------------
  // Power-down: watchdog, status bits and sleep
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      watchdog_counter_out  <= alu_subset_pkg::WDT_CLEAR;
      wdt_prescaler_clr_out <= 1'b0;
      timeout_flag_out      <= 1'b1;
      power_down_flag_out   <= 1'b1;
      sleep_out             <= 1'b0;
    end
    else
    begin
      wdt_prescaler_clr_out <= 1'b0;
      if (sleep_out)
      begin
        // Wake returns to the decode phase of the next cycle
        if (wake_in)
          sleep_out <= 1'b0;
      end
      else if (phase == alu_subset_pkg::PH_WRITE && is_sleep && !skip_cycle)
      begin
        watchdog_counter_out  <= alu_subset_pkg::WDT_CLEAR;
        wdt_prescaler_clr_out <= 1'b1;
        timeout_flag_out      <= 1'b1;
        power_down_flag_out   <= 1'b0;
        sleep_out             <= 1'b1;
      end
      else if (phase == alu_subset_pkg::PH_WRITE)
        watchdog_counter_out <= watchdog_counter_out + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // Direction registers, written by the legacy load
  // ------------------------------------------------------------
  direction_regs #(.WIDTH(DATA_WIDTH), .COUNT(3)) u_dir
  (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .wr_en_in    (phase == alu_subset_pkg::PH_WRITE && is_dir && !skip_cycle && !sleep_out),
    .wr_idx_in   (2'(insn[2:0] - alu_subset_pkg::DIR_LOAD_MIN)),
    .wr_data_in  (acc_out),
    .rd_idx_in   (dir_rd_idx_in),
    .rd_data_out (dir_rdata_out)
  );

  // ------------------------------------------------------------
  // File register port
  // ------------------------------------------------------------
  always_comb
  begin
    phase_out      = phase;
    file_addr_out  = insn[6:0];
    file_rd_out    = (phase == alu_subset_pkg::PH_READ) && !is_lit && writes;
    file_wr_out    = (phase == alu_subset_pkg::PH_WRITE) && writes && to_file && !sleep_out;
    file_wdata_out = result;
    skip_out       = skip_cycle;
    insn_done_out  = (phase == alu_subset_pkg::PH_WRITE) && !sleep_out;
  end

endmodule
`default_nettype wire

// ===== tb/alu_instruction_subset_sva.sv
// Checker for the instruction subset core, bound to its ports
`timescale 1ns/1ns
`default_nettype none
module alu_subset_chk
#(
  parameter int DATA_WIDTH = 8
)
(
  input wire logic                  core_clk_in,
  input wire logic                  nrst_in,
  input wire logic [13:0]           insn_in,
  input wire logic                  insn_valid_in,
  input wire logic [DATA_WIDTH-1:0] file_rdata_in,
  input wire logic [3:0]            phase_out,
  input wire logic                  file_rd_out,
  input wire logic                  file_wr_out,
  input wire logic [DATA_WIDTH-1:0] acc_out,
  input wire logic                  zero_flag_out,
  input wire logic                  carry_flag_out,
  input wire logic                  nibble_borrow_flag_out,
  input wire logic                  timeout_flag_out,
  input wire logic                  power_down_flag_out,
  input wire logic [7:0]            watchdog_counter_out,
  input wire logic                  wdt_prescaler_clr_out,
  input wire logic                  sleep_out,
  input wire logic                  skip_out,
  input wire logic                  insn_done_out
);
  // -------------------------------------------------
  // Decode helpers
  // -------------------------------------------------
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  // A real decode: valid word, previous cycle not discarded, not asleep
  wire logic       dec   = phase_out == 4'h1 && insn_valid_in && !skip_out && !sleep_out;
  wire logic       fgrp  = insn_in[13:12] == alu_subset_pkg::GRP_FILE;
  wire logic [3:0] op    = insn_in[11:8];
  wire logic [7:0] lit   = insn_in[7:0];
  wire logic [2:0] flags = {zero_flag_out, carry_flag_out, nibble_borrow_flag_out};
  sequence s_pd;
    dec && insn_in == alu_subset_pkg::POWER_DOWN_WORD;
  endsequence
  sequence s_dsz;
    dec && fgrp && op == alu_subset_pkg::OP_DEC_SKIP_ZERO;
  endsequence
  // -------------------------------------------------
  // Properties
  // -------------------------------------------------
  property p_phase_seq;
    (phase_out == 4'h1 && !sleep_out) |=> phase_out == 4'h2 ##1 phase_out == 4'h4 ##1 phase_out == 4'h8;
  endproperty
  a_phase_seq: assert property (p_phase_seq) else $error("phase order broken");
  property p_rd;
    file_rd_out |-> phase_out == 4'h2;
  endproperty
  a_rd: assert property (p_rd) else $error("file read outside read phase");
  property p_wr;
    file_wr_out |-> phase_out == 4'h8 && !skip_out;
  endproperty
  a_wr: assert property (p_wr) else $error("file write outside write phase");
  // End of cycle is flagged only in the fourth phase, never while frozen asleep
  property p_done;
    insn_done_out == (phase_out == 4'h8);
  endproperty
  a_done: assert property (p_done) else $error("instruction end not marked in write phase");
  property p_skip;
    s_dsz ##1 file_rdata_in == 8'h01 |-> ##4 skip_out [*4];
  endproperty
  a_skip: assert property (p_skip) else $error("zero result did not discard next");
  property p_no_skip;
    s_dsz ##1 file_rdata_in != 8'h01 |-> ##4 !skip_out;
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("nonzero result discarded next");
  property p_pd;
    s_pd |-> ##4 timeout_flag_out && !power_down_flag_out && watchdog_counter_out == 8'h00 && sleep_out;
  endproperty
  a_pd: assert property (p_pd) else $error("power-down state wrong");
  property p_pd_quiet;
    s_pd |-> (!file_rd_out && !file_wr_out) [*4];
  endproperty
  a_pd_quiet: assert property (p_pd_quiet) else $error("operand activity in power-down");
  property p_presc;
    s_pd |-> ##[1:4] wdt_prescaler_clr_out;
  endproperty
  a_presc: assert property (p_presc) else $error("prescaler not cleared");
  property p_swap;
    dec && fgrp && op == alu_subset_pkg::OP_NIBBLE_EXCH |-> ##4 flags == $past(flags, 4);
  endproperty
  a_swap: assert property (p_swap) else $error("swap changed flags");
  property p_xorl;
    dec && insn_in[13:8] == 6'h3A |-> ##4 acc_out == ($past(acc_out, 4) ^ $past(lit, 4));
  endproperty
  a_xorl: assert property (p_xorl) else $error("literal xor result wrong");
  property p_dec;
    dec && fgrp && op == alu_subset_pkg::OP_DECREMENT_REG && !insn_in[7] |-> ##4 acc_out == $past(file_rdata_in, 3) - 8'h01;
  endproperty
  a_dec: assert property (p_dec) else $error("decrement result wrong");
  property p_comp;
    dec && fgrp && op == alu_subset_pkg::OP_COMPLEMENT && !insn_in[7] |-> ##4 acc_out == ~$past(file_rdata_in, 3);
  endproperty
  a_comp: assert property (p_comp) else $error("complement result wrong");
endmodule
bind alu_instruction_subset alu_subset_chk #(.DATA_WIDTH(DATA_WIDTH)) u_chk (.core_clk_in, .nrst_in, .insn_in,
  .insn_valid_in, .file_rdata_in, .phase_out, .file_rd_out, .file_wr_out, .acc_out, .zero_flag_out, .carry_flag_out,
  .nibble_borrow_flag_out, .timeout_flag_out, .power_down_flag_out, .watchdog_counter_out, .wdt_prescaler_clr_out,
  .sleep_out, .skip_out, .insn_done_out);
`default_nettype wire

// ===== tb/file_model.sv
// Data register file model on the far side of the core
`timescale 1ns/1ns
`default_nettype none
module file_model
(
  input  wire logic       core_clk_in,
  input  wire logic [6:0] addr_in,
  input  wire logic       rd_in,
  input  wire logic       wr_in,
  input  wire logic [7:0] wdata_in,
  output logic      [7:0] rdata_out
);
  logic [7:0] mem [128];  // File contents, preset by the bench
  logic [7:0] last = 8'h00; // Last value read
  // Outside a read the bus shows garbage, so a late sample is caught
  assign rdata_out = rd_in ? mem[addr_in] : ~last;
  // Read capture in the core's read phase, write in its write phase
  always @(posedge core_clk_in)
  begin
    if (rd_in)
      last <= mem[addr_in];
    if (wr_in)
      mem[addr_in] <= wdata_in;
  end
endmodule
`default_nettype wire

// ===== tb/alu_instruction_subset_test.sv
// Self-checking bench for the instruction subset core
`timescale 1ns/1ns
`default_nettype none
module alu_instruction_subset_test;
  // Row: word, file value, expected acc, file, flags z c dc, direction index and value
  typedef struct packed {
    logic [13:0] w;
    logic [7:0]  f;
    logic [7:0]  a;
    logic [7:0]  m;
    logic [2:0]  fl;
    logic [1:0]  di;
    logic [7:0]  dv;
  } row_t;
  row_t rows [20] = '{
    '{14'h3AB5, 8'h00, 8'hB5, 8'h00, 3'h0, 2'h0, 8'hFF}, '{14'h3AAF, 8'h00, 8'h1A, 8'h00, 3'h0, 2'h0, 8'hFF},
    '{14'h06A0, 8'h1A, 8'h1A, 8'h00, 3'h4, 2'h0, 8'hFF}, '{14'h0920, 8'h13, 8'hEC, 8'h13, 3'h0, 2'h0, 8'hFF},
    '{14'h09A0, 8'hFF, 8'hEC, 8'h00, 3'h4, 2'h0, 8'hFF}, '{14'h0320, 8'h01, 8'h00, 8'h01, 3'h4, 2'h0, 8'hFF},
    '{14'h0E20, 8'hA5, 8'h5A, 8'hA5, 3'h4, 2'h0, 8'hFF}, '{14'h03A0, 8'h00, 8'h5A, 8'hFF, 3'h0, 2'h0, 8'hFF},
    '{14'h0EA0, 8'h3C, 8'h5A, 8'hC3, 3'h0, 2'h0, 8'hFF}, '{14'h3A58, 8'h00, 8'h02, 8'h00, 3'h0, 2'h0, 8'hFF},
    '{14'h02A0, 8'h01, 8'h02, 8'hFF, 3'h0, 2'h0, 8'hFF}, '{14'h0220, 8'h03, 8'h01, 8'h03, 3'h3, 2'h0, 8'hFF},
    '{14'h3C01, 8'h00, 8'h00, 8'h00, 3'h7, 2'h0, 8'hFF}, '{14'h0EA0, 8'h0F, 8'h00, 8'hF0, 3'h7, 2'h0, 8'hFF},
    '{14'h3D10, 8'h00, 8'h10, 8'h00, 3'h3, 2'h0, 8'hFF}, '{14'h3C02, 8'h00, 8'hF2, 8'h00, 3'h1, 2'h0, 8'hFF},
    '{14'h0065, 8'h00, 8'hF2, 8'h00, 3'h1, 2'h0, 8'hF2}, '{14'h3AFF, 8'h00, 8'h0D, 8'h00, 3'h1, 2'h1, 8'hFF},
    '{14'h0067, 8'h00, 8'h0D, 8'h00, 3'h1, 2'h2, 8'h0D}, '{14'h3A0D, 8'h00, 8'h00, 8'h00, 3'h5, 2'h2, 8'h0D}};
  logic        core_clk_in   = 1'b0;
  logic        nrst_in       = 1'b0;
  logic [13:0] insn_in       = 14'h0000;
  logic        insn_valid_in = 1'b0;
  logic        wake_in       = 1'b0;
  logic [1:0]  dir_rd_idx_in = 2'h0;
  wire logic [7:0] file_rdata_in, file_wdata_out, acc_out, watchdog_counter_out, dir_rdata_out;
  wire logic [6:0] file_addr_out;
  wire logic [3:0] phase_out;
  wire logic file_rd_out, file_wr_out, zero_flag_out, carry_flag_out, nibble_borrow_flag_out;
  wire logic timeout_flag_out, power_down_flag_out, sleep_out, skip_out;
  // Status packed: sleep, skip, 0, z, c, dc, timeout, power-down
  wire logic [7:0] stat = {sleep_out, skip_out, 1'b0, zero_flag_out, carry_flag_out, nibble_borrow_flag_out,
    timeout_flag_out, power_down_flag_out};
  int bad_count = 0;
  int cmp_count = 0;
  int cycles    = 0;
  int n;
  // -------------------------------------------------
  // Design, register file and clock
  // -------------------------------------------------
  alu_instruction_subset i_dut (.core_clk_in, .nrst_in, .insn_in, .insn_valid_in, .file_rdata_in, .wake_in,
    .phase_out, .file_addr_out, .file_rd_out, .file_wr_out, .file_wdata_out, .acc_out, .zero_flag_out,
    .carry_flag_out, .nibble_borrow_flag_out, .timeout_flag_out, .power_down_flag_out, .watchdog_counter_out,
    .wdt_prescaler_clr_out(), .sleep_out, .skip_out, .insn_done_out(), .dir_rdata_out, .dir_rd_idx_in);
  file_model i_file (.core_clk_in, .addr_in(file_addr_out), .rd_in(file_rd_out), .wr_in(file_wr_out),
    .wdata_in(file_wdata_out), .rdata_out(file_rdata_in));
  always #25 core_clk_in = ~core_clk_in;
  // Hang guard, the run needs well under a thousand cycles
  always @(posedge core_clk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      print_verdict();
    end
  end
  // -------------------------------------------------
  // Tasks
  // -------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Entered at the edge ending a cycle; returns at the edge ending this one
  task automatic exec(input logic [13:0] w);
    insn_in <= w;
    insn_valid_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
  endtask
  // Starts an empty cycle and stops mid-way with results settled
  task automatic idle(input logic [1:0] di);
    insn_valid_in <= 1'b0;
    dir_rd_idx_in <= di;
    @(posedge core_clk_in);
    @(negedge core_clk_in);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // -------------------------------------------------
  // Main sequence
  // -------------------------------------------------
  initial
  begin
    repeat (11) @(posedge core_clk_in);
    @(negedge core_clk_in);
    check(stat, 8'h03);
    check({4'h0, phase_out}, 8'h01);
    check(acc_out, 8'h00);
    @(posedge core_clk_in);
    nrst_in <= 1'b1;
    // Ordinary cases from the table
    foreach (rows[i])
    begin
      i_file.mem[7'h20] = rows[i].f;
      exec(rows[i].w);
      idle(rows[i].di);
      check(acc_out, rows[i].a);
      check(i_file.mem[7'h20], rows[i].m);
      check(stat, {3'h0, rows[i].fl, 2'h3});
      check(dir_rdata_out, rows[i].dv);
      repeat (3) @(posedge core_clk_in);
    end
    // Zero result discards the following write, nonzero does not
    i_file.mem[7'h20] = 8'h01;
    exec(14'h0BA0);
    exec(14'h09A0);
    idle(2'h0);
    check(i_file.mem[7'h20], 8'h00);
    repeat (3) @(posedge core_clk_in);
    i_file.mem[7'h20] = 8'h02;
    exec(14'h0BA0);
    exec(14'h09A0);
    idle(2'h0);
    check(i_file.mem[7'h20], 8'hFE);
    repeat (3) @(posedge core_clk_in);
    // Power-down, then wake and resume
    exec(14'h0063);
    @(negedge core_clk_in);
    check(stat, 8'h86);
    check(watchdog_counter_out, 8'h00);
    @(posedge core_clk_in);
    wake_in <= 1'b1;
    // Fetch a no-op after waking, else the held power-down word is taken again
    insn_valid_in <= 1'b0;
    n = 0;
    while (sleep_out !== 1'b0 && n < 20)
    begin
      @(negedge core_clk_in);
      n++;
    end
    check({7'h0, sleep_out}, 8'h00);
    while (phase_out !== 4'h8 && n < 40)
    begin
      @(negedge core_clk_in);
      n++;
    end
    @(posedge core_clk_in);
    wake_in <= 1'b0;
    exec(14'h3A55);
    idle(2'h0);
    check(acc_out, 8'h55);
    // Second reset in mid-run
    @(posedge core_clk_in);
    nrst_in <= 1'b0;
    @(negedge core_clk_in);
    check(stat, 8'h03);
    check(acc_out, 8'h00);
    check({4'h0, phase_out}, 8'h01);
    @(posedge core_clk_in);
    nrst_in <= 1'b1;
    exec(14'h3A12);
    idle(2'h0);
    check(acc_out, 8'h12);
    print_verdict();
  end
endmodule
`default_nettype wire
